// ---- logic/abla_arbiter.sv ----
// Purpose: lock arbiter for 59 message buffers and their active windows
// Assumes: host on Avalon-MM, protocol engine on the same clock
// Notes: every access takes one wait cycle; results are final at read-back
//
// Notes on behaviour
// RULE1: host writes one to lock bit to request
// RULE2: lock bit written as request, read as grant
// RULE3: read one means locked, else retry request
// RULE4: refusal sets irq flag and error cause
// RULE5: second write of one releases immediately
// RULE6: locked buffer appears in its type's window
// RULE7: granted buffer mirrored into matching window
// RULE8: at most one tx, rx, fifo lock
// RULE9: second lock of a type refused, flagged
// RULE10: fifo release advances fifo access pointer
// RULE11: committed tx buffer lock refused with error
// RULE12: controller half of double buffer unlockable
// RULE13: host half even double, controller half next
// RULE14: two frames while locked: lose older, flag
// RULE15: commit writes only while buffer is locked
// RULE16: lock cycles free; sending needs explicit commit
// RULE17: controller holds committed unlocked scheduled buffer
// RULE18: lock during controller hold refused, busy flag
// RULE19: shadow receive buffers, never host reachable
// RULE20: fifo buffers ignore cycle filter register
// RULE21: each buffer owns lock and commit bits
// RULE22: outcome resolved before next host read
`timescale 1ns/1ps
module abla_arbiter (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // avalon-mm slave
   input wire logic [abla_pkg::ADDR_W-1:0] av_address,
   input wire logic av_read,
   input wire logic av_write,
   input wire logic [31:0] av_writedata,
   input wire logic [3:0] av_byteenable,
   output logic [31:0] av_readdata,
   output logic av_waitrequest,
   // protocol engine transmit side
   input wire logic cc_tx_take,
   input wire logic cc_tx_done,
   input wire logic [abla_pkg::IDX_W-1:0] cc_tx_idx,
   output logic [abla_pkg::NUM_BUF-1:0] tx_commit_vec,
   output logic tx_hold_valid,
   // protocol engine receive side
   input wire logic cc_rx_store,
   input wire logic [abla_pkg::IDX_W-1:0] cc_rx_idx,
   input wire logic [abla_pkg::DATA_W-1:0] cc_rx_data,
   output logic [abla_pkg::NUM_BUF-1:0] cycle_filter_use
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic waitreq;
      logic [31:0] rdata;
      logic [abla_pkg::NUM_BUF-1:0] lock;
      logic [abla_pkg::NUM_BUF-1:0] commit;
      logic [abla_pkg::NUM_BUF-1:0][1:0] btype;
      logic [abla_pkg::NUM_BUF-1:0][abla_pkg::DATA_W-1:0] data;
      logic [abla_pkg::NUM_BUF-1:0][abla_pkg::DATA_W-1:0] shadow;
      logic [abla_pkg::NUM_BUF-1:0] shadow_full;
      logic tx_held;
      logic rx_held;
      logic fifo_held;
      logic [abla_pkg::IDX_W-1:0] tx_idx;
      logic [abla_pkg::IDX_W-1:0] rx_idx;
      logic [abla_pkg::IDX_W-1:0] fifo_idx;
      logic [abla_pkg::IDX_W-1:0] fifo_ptr;
      logic hold_v;
      logic [abla_pkg::IDX_W-1:0] hold_idx;
      logic irq_flag;
      logic [abla_pkg::ERR_W-1:0] err;
      logic cfg_mode;
      logic [abla_pkg::NUM_BUF-1:0] filt_use;
   } abla_state_t;

   abla_state_t st;
   abla_state_t next_st;

   // next fifo-type buffer after idx, wrapping; stays put if none other
   function automatic logic [abla_pkg::IDX_W-1:0] abla_next_fifo(
      input logic [abla_pkg::NUM_BUF-1:0][1:0] types,
      input logic [abla_pkg::IDX_W-1:0] idx);
      logic [abla_pkg::IDX_W-1:0] res;
      logic found;
      int j;
      res = idx;
      found = 1'b0;
      for (int k = 1; k <= abla_pkg::NUM_BUF; k++) begin
         j = (int'(idx) + k) % abla_pkg::NUM_BUF;
         if (!found && types[j] == abla_pkg::TYPE_FIFO) begin
            res = j[abla_pkg::IDX_W-1:0];
            found = 1'b1;
         end
      end
      return res;
   endfunction : abla_next_fifo

   // ----------------------------------------
   // decode
   // ----------------------------------------
   logic [abla_pkg::IDX_W-1:0] widx;
   logic is_buf;
   logic accept;
   logic done;
   logic lo_be;

   always_comb begin
      widx = av_address[abla_pkg::IDX_W+1:2];
      is_buf = (av_address <= abla_pkg::OFS_BUF_LAST) && (av_address[9:8] == 2'h0);
      accept = st.waitreq && (av_read || av_write);
      done = !st.waitreq && av_write;
      lo_be = av_byteenable[0];
   end

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic [1:0] t;
      logic cc_part;
      logic [abla_pkg::IDX_W-1:0] prev;
      logic [abla_pkg::ERR_W-1:0] ev;
      logic [15:0] w;
      t = 2'h0;
      cc_part = 1'b0;
      prev = '0;
      ev = '0;
      w = av_writedata[15:0];
      next_st = st;

      // one wait cycle per access, then ready for one edge
      if (accept) begin
         next_st.waitreq = 1'b0;
      end else begin
         next_st.waitreq = 1'b1;
      end

      // read data captured during the wait cycle, from settled state [RULE22]
      // reads only: a write leaves the last read data standing for the host
      if (accept && av_read) begin
         next_st.rdata = 32'h0000_0000;
         if (is_buf && int'(widx) < abla_pkg::NUM_BUF) begin
            next_st.rdata[abla_pkg::BIT_LOCK] = st.lock[widx]; // [RULE2] [RULE3]
            next_st.rdata[abla_pkg::BIT_COMMIT] = st.commit[widx];
            next_st.rdata[abla_pkg::BIT_TYPE_LO +: 2] = st.btype[widx];
         end else begin
            case (av_address)
               abla_pkg::OFS_INT_STATUS_ZERO: next_st.rdata[0] = st.irq_flag;
               abla_pkg::OFS_HOST_IF_ERROR: next_st.rdata[abla_pkg::ERR_W-1:0] = st.err;
               abla_pkg::OFS_CTRL: next_st.rdata[abla_pkg::BIT_CFG_MODE] = st.cfg_mode;
               abla_pkg::OFS_ACTIVE: next_st.rdata[23:0] = {
                  st.fifo_held, 1'b0, st.fifo_idx,
                  st.rx_held, 1'b0, st.rx_idx,
                  st.tx_held, 1'b0, st.tx_idx};
               // windows mirror the locked buffer's data [RULE6] [RULE7]
               abla_pkg::OFS_WIN_TX: next_st.rdata[15:0] = st.tx_held ? st.data[st.tx_idx] : 16'h0000;
               abla_pkg::OFS_WIN_RX: next_st.rdata[15:0] = st.rx_held ? st.data[st.rx_idx] : 16'h0000;
               abla_pkg::OFS_WIN_FIFO: next_st.rdata[15:0] =
                  st.fifo_held ? st.data[st.fifo_idx] : 16'h0000;
               abla_pkg::OFS_FIFO_PTR: next_st.rdata[abla_pkg::IDX_W-1:0] = st.fifo_ptr;
               default: next_st.rdata = 32'h0000_0000;
            endcase
         end
      end

      // ----------------------------------------
      // host writes, applied at the ready edge
      // ----------------------------------------
      if (done && lo_be) begin
         if (is_buf && int'(widx) < abla_pkg::NUM_BUF) begin
            t = st.btype[widx];
            // buffer 0 has no lower neighbour; widx[0] gates that lookup off
            prev = widx - 6'h01;
            // odd buffer after an even double is the controller half [RULE13]
            cc_part = widx[0] && (st.btype[prev] == abla_pkg::TYPE_TX_DOUBLE);
            // type only changes in configuration state
            if (st.cfg_mode && !st.lock[widx]) begin
               next_st.btype[widx] = w[abla_pkg::BIT_TYPE_LO +: 2];
            end
            // commit takes effect only on a held tx buffer [RULE15] [RULE16]
            if (st.lock[widx] && t != abla_pkg::TYPE_RX && t != abla_pkg::TYPE_FIFO) begin
               next_st.commit[widx] = w[abla_pkg::BIT_COMMIT]; // [RULE21]
            end
            if (w[abla_pkg::BIT_LOCK]) begin // [RULE1]
               if (st.lock[widx]) begin
                  // release is never refused [RULE5]
                  next_st.lock[widx] = 1'b0;
                  case (t)
                     abla_pkg::TYPE_RX: begin
                        next_st.rx_held = 1'b0;
                        // newest frame kept while locked now becomes visible [RULE19]
                        if (st.shadow_full[widx]) begin
                           next_st.data[widx] = st.shadow[widx];
                           next_st.shadow_full[widx] = 1'b0;
                        end
                     end
                     abla_pkg::TYPE_FIFO: begin
                        next_st.fifo_held = 1'b0;
                        next_st.fifo_ptr = abla_next_fifo(st.btype, widx); // [RULE10]
                     end
                     default: next_st.tx_held = 1'b0;
                  endcase
               end else if (cc_part) begin
                  ev[abla_pkg::ERR_CC_PART] = 1'b1; // [RULE12]
               end else begin
                  case (t)
                     abla_pkg::TYPE_RX: begin
                        if (st.rx_held) begin
                           ev[abla_pkg::ERR_RX_LOCK] = 1'b1; // [RULE8] [RULE9]
                        end else begin
                           next_st.lock[widx] = 1'b1;
                           next_st.rx_held = 1'b1;
                           next_st.rx_idx = widx;
                        end
                     end
                     abla_pkg::TYPE_FIFO: begin
                        // only the entry under the pointer may be taken
                        if (st.fifo_held || widx != st.fifo_ptr) begin
                           ev[abla_pkg::ERR_FIFO_LOCK] = 1'b1; // [RULE8] [RULE9] [RULE10]
                        end else begin
                           next_st.lock[widx] = 1'b1;
                           next_st.fifo_held = 1'b1;
                           next_st.fifo_idx = widx;
                        end
                     end
                     default: begin
                        if (st.hold_v && st.hold_idx == widx) begin
                           ev[abla_pkg::ERR_BUSY] = 1'b1; // [RULE18]
                        end else if (st.commit[widx]) begin
                           ev[abla_pkg::ERR_COMMITTED] = 1'b1; // [RULE11]
                        end else if (st.tx_held) begin
                           ev[abla_pkg::ERR_TX_LOCK] = 1'b1; // [RULE8] [RULE9]
                        end else begin
                           next_st.lock[widx] = 1'b1;
                           next_st.tx_held = 1'b1;
                           next_st.tx_idx = widx;
                        end
                     end
                  endcase
               end
            end
         end else begin
            case (av_address)
               // write one to clear; events below set afterwards so they win
               abla_pkg::OFS_INT_STATUS_ZERO:
                  if (w[abla_pkg::BIT_IRQ_FLAG]) next_st.irq_flag = 1'b0;
               abla_pkg::OFS_HOST_IF_ERROR: next_st.err = st.err & ~w[abla_pkg::ERR_W-1:0];
               abla_pkg::OFS_CTRL: next_st.cfg_mode = w[abla_pkg::BIT_CFG_MODE];
               abla_pkg::OFS_WIN_TX: if (st.tx_held) next_st.data[st.tx_idx] = w;
               default: ;
            endcase
         end
      end

      // ----------------------------------------
      // protocol engine events
      // ----------------------------------------
      // hold only a committed buffer the host has let go [RULE17]
      // a take while a hold stands is dropped, so one send at a time
      if (cc_tx_take && !st.hold_v && int'(cc_tx_idx) < abla_pkg::NUM_BUF) begin
         if (st.commit[cc_tx_idx] && !st.lock[cc_tx_idx]) begin
            next_st.hold_v = 1'b1;
            next_st.hold_idx = cc_tx_idx;
         end
      end
      if (cc_tx_done && st.hold_v) begin
         next_st.hold_v = 1'b0;
         next_st.commit[st.hold_idx] = 1'b0;
      end
      if (cc_rx_store && int'(cc_rx_idx) < abla_pkg::NUM_BUF) begin
         if (st.lock[cc_rx_idx] && st.btype[cc_rx_idx] == abla_pkg::TYPE_RX) begin
            // second frame while held: older one dropped [RULE14] [RULE19]
            if (st.shadow_full[cc_rx_idx]) begin
               ev[abla_pkg::ERR_FRAME_LOST] = 1'b1;
            end
            next_st.shadow[cc_rx_idx] = cc_rx_data;
            next_st.shadow_full[cc_rx_idx] = 1'b1;
         end else begin
            next_st.data[cc_rx_idx] = cc_rx_data;
         end
      end

      // causes recorded, summary flag raised [RULE4]
      next_st.err = next_st.err | ev;
      if (ev != '0) begin
         next_st.irq_flag = 1'b1;
      end

      // fifo entries use shared filters, not their own cycle filter [RULE20]
      for (int i = 0; i < abla_pkg::NUM_BUF; i++) begin
         next_st.filt_use[i] = (next_st.btype[i] != abla_pkg::TYPE_FIFO);
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         st <= '0;
         st.waitreq <= 1'b1;
         st.cfg_mode <= abla_pkg::RST_CFG_MODE;
         st.filt_use <= '1;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   always_comb begin
      av_readdata = st.rdata;
      av_waitrequest = st.waitreq;
      tx_commit_vec = st.commit;
      tx_hold_valid = st.hold_v;
      cycle_filter_use = st.filt_use;
   end
endmodule : abla_arbiter

// ---- shared/abla_pkg.sv ----
// Purpose: constants for the active buffer lock arbiter
// Assumes: 32-bit Avalon-MM data, byte addresses, registers in the low 16 bits, active register in the low 24
// Notes: one word per register, buffer n at byte address 4*n
package abla_pkg;
   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int NUM_BUF = 59;
   localparam int IDX_W = 6;
   localparam int DATA_W = 16;
   localparam int ADDR_W = 10;
   localparam int ERR_W = 7;
   // ----------------------------------------
   // register byte offsets
   // ----------------------------------------
   localparam logic [ADDR_W-1:0] OFS_BUF_LAST = 10'h0e8;
   localparam logic [ADDR_W-1:0] OFS_INT_STATUS_ZERO = 10'h100;
   localparam logic [ADDR_W-1:0] OFS_HOST_IF_ERROR = 10'h104;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 10'h108;
   localparam logic [ADDR_W-1:0] OFS_ACTIVE = 10'h10c;
   localparam logic [ADDR_W-1:0] OFS_WIN_TX = 10'h110;
   localparam logic [ADDR_W-1:0] OFS_WIN_RX = 10'h114;
   localparam logic [ADDR_W-1:0] OFS_WIN_FIFO = 10'h118;
   localparam logic [ADDR_W-1:0] OFS_FIFO_PTR = 10'h11c;
   // ----------------------------------------
   // buffer_ctrl_status_reg fields
   // ----------------------------------------
   localparam int BIT_LOCK = 0;
   localparam int BIT_COMMIT = 1;
   localparam int BIT_TYPE_LO = 2;
   localparam logic [1:0] TYPE_RX = 2'h0;
   localparam logic [1:0] TYPE_TX_SINGLE = 2'h1;
   localparam logic [1:0] TYPE_TX_DOUBLE = 2'h2;
   localparam logic [1:0] TYPE_FIFO = 2'h3;
   // ----------------------------------------
   // host_if_error_register bits, irq flag, control
   // ----------------------------------------
   localparam int ERR_FRAME_LOST = 0;
   localparam int ERR_RX_LOCK = 1;
   localparam int ERR_TX_LOCK = 2;
   localparam int ERR_FIFO_LOCK = 3;
   localparam int ERR_BUSY = 4;
   localparam int ERR_COMMITTED = 5;
   localparam int ERR_CC_PART = 6;
   localparam int BIT_IRQ_FLAG = 0;
   localparam int BIT_CFG_MODE = 0;
   localparam logic RST_CFG_MODE = 1'b1;
endpackage : abla_pkg

// ---- testbench/abla_arbiter_asserts.sv ----
// Purpose: port-level checks on the lock arbiter
// Assumes: one clock, synchronous active-low reset
// Notes: hold_idx follows the buffer the engine is sending
`timescale 1ns/1ps
module abla_arbiter_asserts (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // register bus
   input wire logic av_read,
   input wire logic av_write,
   input wire logic [31:0] av_readdata,
   input wire logic av_waitrequest,
   // protocol engine
   input wire logic cc_tx_take,
   input wire logic cc_tx_done,
   input wire logic [abla_pkg::IDX_W-1:0] cc_tx_idx,
   input wire logic [abla_pkg::NUM_BUF-1:0] tx_commit_vec,
   input wire logic tx_hold_valid,
   input wire logic [abla_pkg::NUM_BUF-1:0] cycle_filter_use
);
   logic [abla_pkg::IDX_W-1:0] hold_idx;
   logic take_ok;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);
   // ------------------------------
   // helper logic
   // ------------------------------
   always_ff @(posedge clk_sys) begin
      take_ok <= cc_tx_take && tx_commit_vec[cc_tx_idx];
      // a take during a hold must not move the index
      if (cc_tx_take && !tx_hold_valid) begin
         hold_idx <= cc_tx_idx;
      end
   end
   sequence s_done;
      tx_hold_valid && cc_tx_done;
   endsequence
   sequence s_released;
      !tx_hold_valid && !tx_commit_vec[hold_idx];
   endsequence
   // ------------------------------
   // properties
   // ------------------------------
   a_wait_one: assert property ((av_read || av_write) && av_waitrequest |=>
      !av_waitrequest ##1 av_waitrequest) else $error("wait state not one cycle");
   a_read_stable: assert property ($changed(av_readdata) && $past(nrst) |->
      $past(av_read) && $past(av_waitrequest)) else $error("read data moved unasked");
   a_hold_cause: assert property ($rose(tx_hold_valid) |-> take_ok)
      else $error("hold without committed take");
   a_done_release: assert property (s_done |=> s_released)
      else $error("done did not end hold");
   a_hold_keeps: assert property (tx_hold_valid && !cc_tx_done |=>
      tx_hold_valid && tx_commit_vec[hold_idx]) else $error("hold lost early");
   a_commit_rise: assert property ((tx_commit_vec & ~$past(tx_commit_vec)) != '0 |->
      $past(av_write) && !$past(av_waitrequest)) else $error("commit set without write");
   a_reset_vals: assert property (!$past(nrst) |-> av_waitrequest && av_readdata == '0
      && tx_commit_vec == '0 && !tx_hold_valid && &cycle_filter_use) else $error("bad reset");
   a_filter_hold: assert property ($changed(cycle_filter_use) && $past(nrst) |->
      $past(av_write) && !$past(av_waitrequest)) else $error("filter use moved unasked");
endmodule : abla_arbiter_asserts

bind abla_arbiter abla_arbiter_asserts u_asserts (
   .clk_sys(clk_sys), .nrst(nrst), .av_read(av_read), .av_write(av_write),
   .av_readdata(av_readdata), .av_waitrequest(av_waitrequest), .cc_tx_take(cc_tx_take),
   .cc_tx_done(cc_tx_done), .cc_tx_idx(cc_tx_idx), .tx_commit_vec(tx_commit_vec),
   .tx_hold_valid(tx_hold_valid), .cycle_filter_use(cycle_filter_use)
);

// ---- testbench/abla_host_model.sv ----
// Purpose: host processor model, register bus master
// Assumes: slave answers with waitrequest low
// Notes: released address and data lines show inverted values
`timescale 1ns/1ps
module abla_host_model (
   // clock
   input wire logic clk_sys,
   // register bus master
   output logic [abla_pkg::ADDR_W-1:0] av_address,
   output logic av_read,
   output logic av_write,
   output logic [31:0] av_writedata,
   output logic [3:0] av_byteenable,
   input wire logic [31:0] av_readdata,
   input wire logic av_waitrequest
);
   initial begin
      av_address = '0;
      av_read = 1'b0;
      av_write = 1'b0;
      av_writedata = '0;
      av_byteenable = 4'hf;
   end
   task automatic xfer(input logic w, input logic [abla_pkg::ADDR_W-1:0] a,
         input logic [15:0] d, output logic [15:0] q);
      @(posedge clk_sys);
      av_address <= a;
      av_write <= w;
      av_read <= !w;
      av_writedata <= {16'h0000, d};
      @(posedge clk_sys);
      while (av_waitrequest !== 1'b0) @(posedge clk_sys);
      q = av_readdata[15:0];
      av_read <= 1'b0;
      av_write <= 1'b0;
      av_address <= ~a;
      av_writedata <= ~{16'h0000, d};
   endtask : xfer
endmodule : abla_host_model

// ---- testbench/active_buffer_lock_arbiter_test.sv ----
// Purpose: self-checking bench for the lock arbiter
// Assumes: host model drives the register bus
// Notes: a row is op nibble, address, then write data or expected read
`timescale 1ns/1ps
module active_buffer_lock_arbiter_test;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic cc_tx_take = 1'b0, cc_tx_done = 1'b0, cc_rx_store = 1'b0;
   logic [5:0] cc_tx_idx = 6'h02, cc_rx_idx = 6'h06;
   logic [15:0] cc_rx_data = 16'h0000, q;
   logic [9:0] av_address;
   logic av_read, av_write, av_waitrequest, tx_hold_valid;
   logic [31:0] av_writedata, av_readdata;
   logic [3:0] av_byteenable;
   logic [58:0] tx_commit_vec, cycle_filter_use;
   int fails = 0, n_tests = 0, cyc = 0;
   logic [31:0] rows [60] = '{
      32'h1000_000c, 32'h1004_000c, 32'h1008_0004, 32'h100c_0004, 32'h1010_0008,
      32'h1014_0004, 32'h0108_0001, 32'h1108_0000, 32'h0008_0004, 32'h1008_0001,
      32'h0008_0005, 32'h010c_0082, 32'h100c_0001, 32'h000c_0004, 32'h0104_0004,
      32'h0100_0001, 32'h1104_007f, 32'h1100_0001, 32'h1018_0001, 32'h0018_0001,
      32'h101c_0001, 32'h001c_0000, 32'h0104_0002, 32'h1104_007f, 32'h1004_0001,
      32'h0104_0008, 32'h1104_007f, 32'h1000_0001, 32'h0000_000d, 32'h010c_8682,
      32'h1000_0001, 32'h011c_0001, 32'h0000_000c, 32'h1000_0001, 32'h0000_000c,
      32'h0104_0008, 32'h1104_007f, 32'h1008_0002, 32'h0008_0007, 32'h1008_0003,
      32'h0008_0006, 32'h1008_0001, 32'h0008_0006, 32'h0104_0020, 32'h1104_007f,
      32'h100c_0002, 32'h000c_0004, 32'h1014_0001, 32'h0014_0004, 32'h0104_0040,
      32'h1104_007f, 32'h1010_0001, 32'h0010_0009, 32'h1010_0001, 32'h0010_0008,
      32'h1018_0001, 32'h0018_0000, 32'h0200_0000, 32'h1200_ffff, 32'h1104_007f};
   always #25 clk_sys = ~clk_sys;
   abla_arbiter u_dut (.clk_sys(clk_sys), .nrst(nrst), .av_address(av_address),
      .av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
      .av_byteenable(av_byteenable), .av_readdata(av_readdata),
      .av_waitrequest(av_waitrequest), .cc_tx_take(cc_tx_take), .cc_tx_done(cc_tx_done),
      .cc_tx_idx(cc_tx_idx), .tx_commit_vec(tx_commit_vec), .tx_hold_valid(tx_hold_valid),
      .cc_rx_store(cc_rx_store), .cc_rx_idx(cc_rx_idx), .cc_rx_data(cc_rx_data),
      .cycle_filter_use(cycle_filter_use));
   abla_host_model u_host (.clk_sys(clk_sys), .av_address(av_address), .av_read(av_read),
      .av_write(av_write), .av_writedata(av_writedata), .av_byteenable(av_byteenable),
      .av_readdata(av_readdata), .av_waitrequest(av_waitrequest));
   // ------------------------------
   // tasks
   // ------------------------------
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic [31:0] r);
      logic [9:0] a;
      a = r[25:16];
      u_host.xfer(r[28], a, r[15:0], q);
      if (!r[28] && a < 10'h100) chk(q, r[15:0]);
      if (!r[28] && a[9:3] == 7'h20) chk(q, r[15:0]);
      if (!r[28] && a > 10'h107) chk(q, r[15:0]);
   endtask : bus
   task final_report;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : final_report
   always @(posedge clk_sys) begin
      cyc++;
      // a whole run needs well under a thousand cycles
      if (cyc == 4000) begin
         fails++;
         final_report();
      end
   end
   // ------------------------------
   // main sequence
   // ------------------------------
   initial begin
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      chk(cycle_filter_use, {59{1'b1}});
      foreach (rows[i]) bus(rows[i]);
      chk(cycle_filter_use, {{57{1'b1}}, 2'h0});
      $display("test register rows done");
      cc_tx_take <= 1'b1;
      @(posedge clk_sys);
      cc_tx_take <= 1'b0;
      @(posedge clk_sys);
      chk(tx_hold_valid, 1'b1);
      bus(32'h1008_0001);
      u_host.xfer(1'b0, 10'h104, 16'h0000, q);
      chk(q, 16'h0010);
      bus(32'h1104_007f);
      cc_tx_done <= 1'b1;
      @(posedge clk_sys);
      cc_tx_done <= 1'b0;
      @(posedge clk_sys);
      chk({tx_hold_valid, tx_commit_vec[2]}, 2'h0);
      bus(32'h1008_0001);
      bus(32'h0008_0005);
      chk(tx_commit_vec[2], 1'b0);
      bus(32'h1008_0001);
      $display("test engine hold done");
      cc_rx_data <= 16'h1234;
      cc_rx_store <= 1'b1;
      @(posedge clk_sys);
      cc_rx_store <= 1'b0;
      bus(32'h1018_0001);
      u_host.xfer(1'b0, 10'h114, 16'h0000, q);
      chk(q, 16'h1234);
      cc_rx_data <= 16'h5678;
      cc_rx_store <= 1'b1;
      @(posedge clk_sys);
      cc_rx_data <= 16'h9abc;
      @(posedge clk_sys);
      cc_rx_store <= 1'b0;
      u_host.xfer(1'b0, 10'h114, 16'h0000, q);
      chk(q, 16'h1234);
      u_host.xfer(1'b0, 10'h104, 16'h0000, q);
      chk(q, 16'h0001);
      bus(32'h1018_0001);
      bus(32'h1018_0001);
      u_host.xfer(1'b0, 10'h114, 16'h0000, q);
      chk(q, 16'h9abc);
      $display("test receive shadow done");
      nrst <= 1'b0;
      @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      chk(cycle_filter_use, {59{1'b1}});
      bus(32'h0108_0001);
      $display("test mid-run reset done");
      final_report();
   end
endmodule : active_buffer_lock_arbiter_test
